// *** rtl/fsc_regs.svh ***
`ifndef FSC_REGS_SVH
`define FSC_REGS_SVH

// register word indices on the control bus (byte address bits 7:2)
`define FSC_OFS_ADDR 6'h00
`define FSC_OFS_WDATA 6'h01
`define FSC_OFS_CMD 6'h02
`define FSC_OFS_STAT 6'h03

// command register bits (write one to start)
`define FSC_CMD_WRITE 0
`define FSC_CMD_READ 1
`define FSC_CMD_POLL 2
`define FSC_CMD_ABORT 3
`define FSC_CMD_CHKWR 4

// status register bits
`define FSC_ST_BUSY 0
`define FSC_ST_OK 1
`define FSC_ST_FAIL 2
`define FSC_ST_REJ 3
`define FSC_ST_LATE 4
`define FSC_ST_DATA_LO 8

// status bit positions on the byte data bus
`define FSC_BIT_TOGGLE 6
`define FSC_BIT_LIMIT 5
`define FSC_BIT_WINDOW 3

// reset command byte, address is don't care
`define FSC_RESET_CMD 8'hF0
`define FSC_RESP_OKAY 2'h0
`define FSC_RESP_SLVERR 2'h2

// timing: clock period, strobe cycle time, read-to-read hold, load window
`define FSC_T_CLK_NS 5
`define FSC_T_CYCLE_NS 55
`define FSC_T_RECOV_NS 10
`define FSC_T_LOAD_US 50
`define FSC_WR_CYC ((`FSC_T_CYCLE_NS + `FSC_T_CLK_NS - 1) / `FSC_T_CLK_NS)
`define FSC_RD_CYC (`FSC_WR_CYC + 2)
`define FSC_RECOV_CYC ((`FSC_T_RECOV_NS + `FSC_T_CLK_NS - 1) / `FSC_T_CLK_NS)
`define FSC_LOAD_WIN_CYC ((`FSC_T_LOAD_US * 1000) / `FSC_T_CLK_NS)

`endif

// *** rtl/fsc_pkg.sv ***
`default_nettype none
package fsc_pkg;
  typedef enum logic [1:0] {
    CY_IDLE = 2'b00,
    CY_ACT = 2'b01,
    CY_REC = 2'b10
  } fsc_cyc_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_WR = 4'b0001,
    S_RD = 4'b0010,
    S_P1 = 4'b0011,
    S_P2 = 4'b0100,
    S_P3 = 4'b0101,
    S_P4 = 4'b0110,
    S_PRST = 4'b0111,
    S_C1 = 4'b1000,
    S_C2 = 4'b1001,
    S_C3 = 4'b1010
  } fsc_op_t;

  typedef logic [18:0] fsc_addr_t;
  typedef logic [7:0] fsc_byte_t;
endpackage
`default_nettype wire

// *** rtl/fsc_cycle.sv ***
`include "fsc_regs.svh"
`default_nettype none
module fsc_cycle import fsc_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic req,
  input wire logic wr,
  input wire fsc_addr_t addr,
  input wire fsc_byte_t wdata,
  output logic done,
  output fsc_byte_t rdata,
  output fsc_addr_t fl_addr,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n,
  output fsc_byte_t fl_dq_out,
  output logic fl_dq_oe_n,
  input wire fsc_byte_t fl_dq_in
);
  fsc_cyc_t st_r;
  logic [4:0] cnt_r;
  logic wr_r;
  fsc_byte_t dq_s1_r;
  fsc_byte_t dq_s2_r;

  // two-stage synchroniser on the data pins
  always_ff @(posedge aclk) begin
    dq_s1_r <= fl_dq_in;
    dq_s2_r <= dq_s1_r;
  end

  // one strobe cycle: assert, hold, release, recover
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= CY_IDLE;
      cnt_r <= 5'h00;
      wr_r <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
      fl_addr <= 19'h00000;
      fl_ce_n <= 1'b1;
      fl_we_n <= 1'b1;
      fl_oe_n <= 1'b1;
      fl_dq_out <= 8'h00;
      fl_dq_oe_n <= 1'b1;
    end else begin
      done <= 1'b0;
      unique case (st_r)
        CY_IDLE: if (req) begin
          fl_addr <= addr;
          fl_ce_n <= 1'b0;
          fl_we_n <= !wr;
          fl_oe_n <= wr;
          fl_dq_out <= wdata;
          fl_dq_oe_n <= !wr;
          wr_r <= wr;
          cnt_r <= wr ? 5'(`FSC_WR_CYC - 1) : 5'(`FSC_RD_CYC - 1);
          st_r <= CY_ACT;
        end
        CY_ACT: if (cnt_r == 5'h00) begin
          fl_ce_n <= 1'b1;
          fl_we_n <= 1'b1;
          fl_oe_n <= 1'b1;
          if (!wr_r) begin
            rdata <= dq_s2_r;
          end
          cnt_r <= 5'(`FSC_RECOV_CYC - 1);
          st_r <= CY_REC;
        end else begin
          cnt_r <= cnt_r - 5'h01;
        end
        CY_REC: begin
          fl_dq_oe_n <= 1'b1;
          if (cnt_r == 5'h00) begin
            done <= 1'b1;
            st_r <= CY_IDLE;
          end else begin
            cnt_r <= cnt_r - 5'h01;
          end
        end
        default: st_r <= CY_IDLE;
      endcase
    end
  end

  // write only with both enables low and output enable high
  AST_WR_INHIBIT: assert property (@(posedge aclk) disable iff (!aresetn)
    !fl_we_n |-> !fl_ce_n && fl_oe_n && !fl_dq_oe_n)
    else $error("write strobe without chip enable or with output enable");
  // a write pulse stays low long enough to pass the glitch filter
  AST_WE_WIDTH: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(fl_we_n) |-> !fl_we_n [*8])
    else $error("write strobe pulse too short");
  // read frame: chip and output enable low, bus not driven
  AST_RD_FRAME: assert property (@(posedge aclk) disable iff (!aresetn)
    !fl_oe_n |-> !fl_ce_n && fl_we_n && fl_dq_oe_n)
    else $error("read frame with write strobe or bus driven");
endmodule
`default_nettype wire

// *** rtl/fsc_host.sv ***
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`include "fsc_regs.svh"
`default_nettype none
// Function
// - reads framed by output or chip enable
// - host reads twice, compares toggle bit
// - toggling with limit flag: recheck, reset
// - resumed polling restarts from double read
// - host checks window flag around adds
// - write needs enables low, output high
// - next sector load within fifty microseconds
module fsc_host import fsc_pkg::*; #(
  parameter int LOAD_WIN_CYC = `FSC_LOAD_WIN_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output fsc_addr_t fl_addr,
  output logic fl_ce_n,
  output logic fl_we_n,
  output logic fl_oe_n,
  output fsc_byte_t fl_dq_out,
  output logic fl_dq_oe_n,
  input wire fsc_byte_t fl_dq_in
);
  // byte-lane merge for word writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  fsc_op_t st_r;
  logic aw_hold_r, w_hold_r, issued_r, abort_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  fsc_addr_t addr_r;
  fsc_byte_t wdat_r, rd_last_r;
  logic tog_r, ok_r, fail_r, rej_r, late_r;
  logic [13:0] gap_r;
  logic cyc_done;
  fsc_byte_t cyc_rdata;

  // bus handshake decode
  wire aw_take = s_axi_awready && s_axi_awvalid;
  wire w_take = s_axi_wready && s_axi_wvalid;
  wire b_done = s_axi_bvalid && s_axi_bready;
  wire ar_take = s_axi_arready && s_axi_arvalid;
  wire aw_hold_nxt = (aw_hold_r || aw_take) && !b_done;
  wire w_hold_nxt = (w_hold_r || w_take) && !b_done;
  wire wr_fire = aw_hold_r && w_hold_r && !s_axi_bvalid;
  wire [5:0] wr_idx = awaddr_r[7:2];
  wire [5:0] rd_idx = s_axi_araddr[7:2];
  wire wr_hit = wr_idx <= `FSC_OFS_STAT;
  wire rd_hit = rd_idx <= `FSC_OFS_STAT;
  wire cmd_go = wr_fire && wr_idx == `FSC_OFS_CMD && wstrb_r[0] && st_r == S_IDLE;
  wire [31:0] addr_mrg = lane_merge({13'h0000, addr_r}, wdata_r, wstrb_r);
  wire [31:0] wdat_mrg = lane_merge({24'h000000, wdat_r}, wdata_r, wstrb_r);

  // status word and read mux
  wire [31:0] stat_w = {16'h0000, rd_last_r, 3'h0, late_r, rej_r, fail_r, ok_r,
                        st_r != S_IDLE};
  wire [31:0] rd_mux = rd_idx == `FSC_OFS_ADDR ? {13'h0000, addr_r} :
                       rd_idx == `FSC_OFS_WDATA ? {24'h000000, wdat_r} :
                       rd_idx == `FSC_OFS_STAT ? stat_w : 32'h00000000;

  // strobe cycle requests
  wire cyc_req = st_r != S_IDLE && !issued_r;
  wire cyc_wr = st_r == S_WR || st_r == S_PRST || st_r == S_C2;
  wire [7:0] cyc_wdata = st_r == S_PRST ? `FSC_RESET_CMD : wdat_r;
  wire tog_now = cyc_rdata[`FSC_BIT_TOGGLE];
  wire tog_same = tog_now == tog_r;
  wire win_late = gap_r >= 14'(LOAD_WIN_CYC);

  // write address and data channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      s_axi_awready <= !aw_hold_nxt;
      s_axi_wready <= !w_hold_nxt;
      if (aw_take) awaddr_r <= s_axi_awaddr;
      if (w_take) wdata_r <= s_axi_wdata;
      if (w_take) wstrb_r <= s_axi_wstrb;
    end
  end

  // write response and read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FSC_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `FSC_RESP_OKAY;
    end else begin
      if (wr_fire) s_axi_bresp <= wr_hit ? `FSC_RESP_OKAY : `FSC_RESP_SLVERR;
      s_axi_bvalid <= wr_fire || (s_axi_bvalid && !s_axi_bready);
      s_axi_arready <= !(ar_take || (s_axi_rvalid && !s_axi_rready));
      s_axi_rvalid <= ar_take || (s_axi_rvalid && !s_axi_rready);
      if (ar_take) s_axi_rdata <= rd_mux;
      if (ar_take) s_axi_rresp <= rd_hit ? `FSC_RESP_OKAY : `FSC_RESP_SLVERR;
    end
  end

  // software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_r <= 19'h00000;
      wdat_r <= 8'h00;
    end else if (wr_fire) begin
      if (wr_idx == `FSC_OFS_ADDR) addr_r <= addr_mrg[18:0];
      if (wr_idx == `FSC_OFS_WDATA) wdat_r <= wdat_mrg[7:0];
    end
  end

  // cycles since the last write cycle finished its recovery, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_r <= 14'h0000;
    end else if (cyc_done && cyc_wr) begin
      gap_r <= 14'h0000;
    end else if (!win_late) begin
      gap_r <= gap_r + 14'h0001;
    end
  end

  // abort request, taken at the end of a poll's first read or of a toggling second read without the limit flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      abort_r <= 1'b0;
    end else if (wr_fire && wr_idx == `FSC_OFS_CMD && wdata_r[`FSC_CMD_ABORT]) begin
      abort_r <= st_r != S_IDLE;
    end else if (st_r == S_IDLE) begin
      abort_r <= 1'b0;
    end
  end

  // operation sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= S_IDLE;
      issued_r <= 1'b0;
      tog_r <= 1'b0;
      rd_last_r <= 8'h00;
      ok_r <= 1'b0;
      fail_r <= 1'b0;
      rej_r <= 1'b0;
      late_r <= 1'b0;
    end else begin
      if (cyc_req) issued_r <= 1'b1;
      if (cyc_done) issued_r <= 1'b0;
      if (cyc_done && !cyc_wr) rd_last_r <= cyc_rdata;
      if (cmd_go) begin
        if (wdata_r[`FSC_CMD_POLL]) begin
          st_r <= S_P1;
          ok_r <= 1'b0;
          fail_r <= 1'b0;
        end else if (wdata_r[`FSC_CMD_CHKWR]) begin
          st_r <= S_C1;
          rej_r <= 1'b0;
          late_r <= 1'b0;
        end else if (wdata_r[`FSC_CMD_WRITE]) begin
          st_r <= S_WR;
        end else if (wdata_r[`FSC_CMD_READ]) begin
          st_r <= S_RD;
        end
      end else if (cyc_done) begin
        unique case (st_r)
          S_WR, S_RD: st_r <= S_IDLE;
          S_P1: begin
            tog_r <= tog_now;
            st_r <= abort_r ? S_IDLE : S_P2;
          end
          S_P2: begin
            if (tog_same) begin
              ok_r <= 1'b1;
              st_r <= S_IDLE;
            end else if (cyc_rdata[`FSC_BIT_LIMIT]) begin
              st_r <= S_P3;
            end else begin
              st_r <= abort_r ? S_IDLE : S_P1;
            end
          end
          S_P3: begin
            tog_r <= tog_now;
            st_r <= S_P4;
          end
          S_P4: begin
            if (tog_same) begin
              ok_r <= 1'b1;
              st_r <= S_IDLE;
            end else begin
              st_r <= S_PRST;
            end
          end
          S_PRST: begin
            fail_r <= 1'b1;
            st_r <= S_IDLE;
          end
          S_C1: begin
            rej_r <= cyc_rdata[`FSC_BIT_WINDOW];
            st_r <= cyc_rdata[`FSC_BIT_WINDOW] ? S_IDLE : S_C2;
          end
          S_C2: st_r <= S_C3;
          S_C3: begin
            rej_r <= cyc_rdata[`FSC_BIT_WINDOW];
            st_r <= S_IDLE;
          end
          default: st_r <= S_IDLE;
        endcase
      end
      if (cyc_req && st_r == S_C2 && win_late) late_r <= 1'b1;
    end
  end

  fsc_cycle u_cycle (
    .aclk(aclk),
    .aresetn(aresetn),
    .req(cyc_req),
    .wr(cyc_wr),
    .addr(addr_r),
    .wdata(cyc_wdata),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .fl_addr(fl_addr),
    .fl_ce_n(fl_ce_n),
    .fl_we_n(fl_we_n),
    .fl_oe_n(fl_oe_n),
    .fl_dq_out(fl_dq_out),
    .fl_dq_oe_n(fl_dq_oe_n),
    .fl_dq_in(fl_dq_in)
  );

  // second poll read always follows a first one
  AST_POLL_PAIR: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r == S_P2 && $past(st_r) != S_P2 |-> $past(st_r) == S_P1)
    else $error("second poll read without a first");
  // equal toggle on the second read declares success
  AST_POLL_OK: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r == S_P2 && cyc_done && tog_same |=> ok_r && st_r == S_IDLE)
    else $error("steady toggle not reported as done");
  // failure only after the reset command write
  AST_FAIL_RESET: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(fail_r) |-> $past(st_r) == S_PRST && $past(cyc_done))
    else $error("failure flagged without reset command");
  // toggling with limit flag high leads to a recheck
  AST_RECHECK: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r == S_P2 && cyc_done && !tog_same && cyc_rdata[`FSC_BIT_LIMIT] |=> st_r == S_P3)
    else $error("limit flag did not trigger recheck");
  // toggling without limit restarts from the first read
  AST_RESTART: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r == S_P2 && cyc_done && !tog_same && !cyc_rdata[`FSC_BIT_LIMIT] |=>
    st_r == S_P1 || st_r == S_IDLE)
    else $error("polling resumed mid-procedure");
  // window flag high after the add marks it rejected
  AST_ADD_REJ: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r == S_C3 && cyc_done |=> rej_r == $past(cyc_rdata[`FSC_BIT_WINDOW]))
    else $error("window flag after add not reported");
  // late sector load flagged when the gap reaches the window
  AST_LATE: assert property (@(posedge aclk) disable iff (!aresetn)
    cyc_req && st_r == S_C2 && gap_r >= 14'(LOAD_WIN_CYC) |=> late_r)
    else $error("late sector load not flagged");
endmodule
`default_nettype wire

// *** verif/fsc_flash_model.sv ***
`default_nettype none
module fsc_flash_model import fsc_pkg::*; (
  input wire fsc_addr_t fl_addr,
  input wire logic fl_ce_n,
  input wire logic fl_we_n,
  input wire logic fl_oe_n,
  input wire fsc_byte_t fl_dq_out,
  input wire logic fl_dq_oe_n,
  output fsc_byte_t fl_dq_in,
  input wire logic arm,
  input wire logic [7:0] arm_reads,
  input wire logic arm_limit,
  input wire logic arm_erase,
  input wire logic arm_win,
  output logic busy,
  output logic [15:0] wr_cnt,
  output fsc_addr_t wr_addr,
  output fsc_byte_t wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left;
  logic lim, ers, win, t6, t2, pd7, rd_arm;
  realtime t_wr;
  fsc_byte_t mem [16];
  fsc_byte_t dout, last_q;
  wire rd_on = !fl_ce_n && !fl_oe_n;
  wire wr_on = !fl_ce_n && !fl_we_n && fl_oe_n;
  // status byte while busy, array data otherwise
  assign busy = (left != 8'h00) || lim;
  assign dout = busy ? {ers ? 1'b0 : ~pd7, t6, lim, 1'b0, ers & win, t2, 2'b00}
    : mem[fl_addr[3:0]];
  // released bus shows the inverse of the last byte
  assign fl_dq_in = rd_on ? dout : ~last_q;
  // power-up lands in read-array mode
  initial begin
    {left, lim, ers, win, t6, t2, pd7, rd_arm} = '0;
    wr_cnt = 16'h0000;
    wr_addr = '0;
    wr_data = 8'h00;
    last_q = 8'h00;
    t_wr = 1.0e9;
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  // bench arms an operation
  always @(posedge arm) begin
    left = arm_reads;
    lim = arm_limit;
    ers = arm_erase;
    win = arm_win;
  end
  // toggles advance once per finished read
  always @(posedge rd_on) rd_arm = 1'b1;
  always @(negedge rd_on) begin
    if (rd_arm) begin
      last_q = dout;
      if (busy) begin
        t6 = ~t6;
        t2 = t2 ^ ers;
        if (!lim && left != 8'h00) left = left - 8'h01;
      end
    end
    rd_arm = 1'b0;
  end
  // writes: strobes must stay low past the glitch floor
  always @(posedge wr_on) t_wr = $realtime;
  always @(negedge wr_on) begin
    if ($realtime - t_wr >= 5.0 && !fl_dq_oe_n) begin
      if (fl_dq_out == 8'hF0 && (lim || left == 8'h00)) begin
        left = 8'h00;
        lim = 1'b0;
      end else if (!busy || (ers && !win)) begin
        wr_cnt = wr_cnt + 16'h0001;
        wr_addr = fl_addr;
        wr_data = fl_dq_out;
        if (!busy) begin
          mem[fl_addr[3:0]] = fl_dq_out;
          pd7 = fl_dq_out[7];
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
`include "fsc_regs.svh"
`default_nettype none
module testbench import fsc_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} fsc_exp_t;
  localparam int LWIN = 200;
  localparam logic [7:0] A_ADDR = {`FSC_OFS_ADDR, 2'b00};
  localparam logic [7:0] A_WDAT = {`FSC_OFS_WDATA, 2'b00};
  localparam logic [7:0] A_CMD = {`FSC_OFS_CMD, 2'b00};
  localparam logic [7:0] A_STAT = {`FSC_OFS_STAT, 2'b00};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0, ws = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ce_n, we_n, oe_n, dq_oe_n, mbusy;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, v, ra, rb;
  fsc_addr_t fl_addr, waddr;
  fsc_byte_t dq_out, dq_in, wdat;
  logic arm = 1'b0, arm_limit = 1'b0, arm_erase = 1'b0, arm_win = 1'b0;
  logic [7:0] arm_reads = 8'h00;
  logic [15:0] wcnt, c0;
  fsc_exp_t qb[$], qr[$], eb, er;
  int err_total = 0, checks = 0, seed = 94, k;

  fsc_host #(.LOAD_WIN_CYC(LWIN)) uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fl_addr(fl_addr), .fl_ce_n(ce_n), .fl_we_n(we_n), .fl_oe_n(oe_n),
    .fl_dq_out(dq_out), .fl_dq_oe_n(dq_oe_n), .fl_dq_in(dq_in));
  fsc_flash_model mdl (.fl_addr(fl_addr), .fl_ce_n(ce_n), .fl_we_n(we_n), .fl_oe_n(oe_n),
    .fl_dq_out(dq_out), .fl_dq_oe_n(dq_oe_n), .fl_dq_in(dq_in), .arm(arm),
    .arm_reads(arm_reads), .arm_limit(arm_limit), .arm_erase(arm_erase), .arm_win(arm_win),
    .busy(mbusy), .wr_cnt(wcnt), .wr_addr(waddr), .wr_data(wdat));

  // clock
  always #2.5 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    checks++;
    if (((got ^ exp) & m) !== 32'h0) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("err_total %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
    qb.push_back('{32'h0, 32'h0, rs});
    awaddr <= a;
    wdata <= d;
    wstrb <= ws;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge aclk);
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] rs, output logic [31:0] d);
    qr.push_back('{e, m, rs});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic cmd(input logic [4:0] c);
    wr(A_CMD, {27'h0, c}, `FSC_RESP_OKAY);
  endtask

  task automatic idle();
    logic [31:0] s;
    s = 32'h1;
    while (s[0] !== 1'b0) rd(A_STAT, 32'h0, 32'h0, `FSC_RESP_OKAY, s);
  endtask

  task automatic arm_dev(input logic [7:0] n, input logic l, input logic e, input logic w);
    arm_reads <= n;
    arm_limit <= l;
    arm_erase <= e;
    arm_win <= w;
    arm <= 1'b1;
    @(posedge aclk);
    arm <= 1'b0;
    @(posedge aclk);
  endtask

  // compare each answer with the oldest note
  always @(posedge aclk) begin
    if (bvalid && bready) begin
      eb = qb.pop_front();
      chk({30'h0, bresp}, {30'h0, eb.r}, 32'h3);
    end
    if (rvalid && rready) begin
      er = qr.pop_front();
      chk(rdata, er.d, er.m);
      chk({30'h0, rresp}, {30'h0, er.r}, 32'h3);
    end
  end

  // main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(A_STAT, 32'h0, 32'hFF1F, `FSC_RESP_OKAY, v);
    rd(A_CMD, 32'h0, 32'hFFFFFFFF, `FSC_RESP_OKAY, v);
    rd(8'h14, 32'h0, 32'hFFFFFFFF, `FSC_RESP_SLVERR, v);
    wr(8'h14, 32'hFFFFFFFF, `FSC_RESP_SLVERR);
    // program a random byte, then read it back
    ra = $random(seed);
    rb = $random(seed);
    rb[0] = 1'b1;
    wr(A_ADDR, {13'h0, ra[18:0]}, `FSC_RESP_OKAY);
    wr(A_WDAT, {24'h0, rb[7:0]}, `FSC_RESP_OKAY);
    cmd(5'h01);
    idle();
    chk({16'h0, wcnt}, 32'h1, 32'hFFFF);
    chk({13'h0, waddr}, {13'h0, ra[18:0]}, 32'h7FFFF);
    chk({24'h0, wdat}, {24'h0, rb[7:0]}, 32'hFF);
    cmd(5'h02);
    idle();
    rd(A_STAT, {16'h0, rb[7:0], 8'h0}, 32'hFF01, `FSC_RESP_OKAY, v);
    // lane 0 off: data byte kept, command not started
    ws = 4'hE;
    wr(A_WDAT, ra, `FSC_RESP_OKAY);
    c0 = wcnt;
    cmd(5'h01);
    ws = 4'hF;
    idle();
    chk({16'h0, wcnt}, {16'h0, c0}, 32'hFFFF);
    rd(A_WDAT, {24'h0, rb[7:0]}, 32'hFFFFFFFF, `FSC_RESP_OKAY, v);
    rd(A_ADDR, {13'h0, ra[18:0]}, 32'hFFFFFFFF, `FSC_RESP_OKAY, v);
    // poll: program busy, program past its limit, erase busy
    for (k = 0; k < 3; k++) begin
      arm_dev(8'h05, k == 1, k == 2, 1'b1);
      cmd(5'h04);
      idle();
      rd(A_STAT, k == 1 ? 32'h4 : 32'h2, 32'h7, `FSC_RESP_OKAY, v);
      chk({31'h0, mbusy}, 32'h0, 32'h1);
    end
    // sector adds: window open, prompt, late, then closed
    arm_dev(8'hFF, 1'b0, 1'b1, 1'b0);
    c0 = wcnt;
    cmd(5'h10);
    idle();
    rd(A_STAT, 32'h0, 32'h8, `FSC_RESP_OKAY, v);
    chk({16'h0, wcnt}, {16'h0, c0 + 16'h1}, 32'hFFFF);
    cmd(5'h10);
    idle();
    rd(A_STAT, 32'h0, 32'h18, `FSC_RESP_OKAY, v);
    repeat (LWIN + 20) @(posedge aclk);
    cmd(5'h10);
    idle();
    rd(A_STAT, 32'h10, 32'h18, `FSC_RESP_OKAY, v);
    arm_dev(8'hFF, 1'b0, 1'b1, 1'b1);
    c0 = wcnt;
    cmd(5'h10);
    idle();
    rd(A_STAT, 32'h8, 32'h8, `FSC_RESP_OKAY, v);
    chk({16'h0, wcnt}, {16'h0, c0}, 32'hFFFF);
    // abort a poll that never settles; a write order meanwhile is dropped
    arm_dev(8'hFF, 1'b0, 1'b0, 1'b0);
    cmd(5'h04);
    repeat (40) @(posedge aclk);
    c0 = wcnt;
    cmd(5'h01);
    cmd(5'h08);
    idle();
    rd(A_STAT, 32'h0, 32'h7, `FSC_RESP_OKAY, v);
    chk({16'h0, wcnt}, {16'h0, c0}, 32'hFFFF);
    report_and_stop();
  end

  // cut a hang short
  initial begin
    #300000;
    err_total++;
    report_and_stop();
  end
endmodule
`default_nettype wire
